// ==== src/usb_irq_identify_and_clock_gate.sv ====
// USB clock gate and interrupt identification subregisters.
//
// Operation
// R1: Any write to the clock stop subregister stops the module clock.
// R2: Clock stop subregister is write-only, reads zero, resets to zero.
// R3: Source code subregister sits at subaddress 28h, read-only, resets zero.
// R4: Raising a request updates the code to name its source.
// R5: Code occupies bits 6 to 2; bits 7, 1 and 0 read zero.
// R6: Only the highest-priority pending request is reported; lowest code wins.
// R7: Codes 0, 1, 2 are setup data, start of frame, setup token.
// R8: Code 3 is suspend, 4 bus reset; code 5 is never reported.
// R9: Code 6 is IN endpoint 0, code 7 OUT endpoint 0.
// R10: Code 8 is IN endpoint 1, code 9 OUT endpoint 1.
// R11: Code 11 is OUT endpoint 2.
// R12: Code 13 is OUT endpoint 3, the lowest priority.
// R13: Software writes zero to reserved bits and ignores them.
// R14: Code 10 is IN endpoint 2, code 12 IN endpoint 3.
// R15: IN flag sets after a sent packet is acknowledged by the host.
// R16: OUT flag sets on an error-free received packet.
// R17: Flags clear only by writing one; the code then moves on.
`include "usb_irq_cfg.svh"
`default_nettype none
module usb_irq_identify_and_clock_gate #(
  parameter int NUM_EP = `USB_NUM_ENDPOINTS
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               reset,
  // Subregister select and subdata access
  input  wire logic               select_write,
  input  wire logic               select_read,
  input  wire logic               data_write,
  input  wire logic               data_read,
  input  wire usb_irq_pkg::byte_t write_data,
  output usb_irq_pkg::byte_t      read_data,
  // General bus events, one-cycle pulses
  input  wire logic               setup_data_event,
  input  wire logic               frame_event,
  input  wire logic               setup_token_event,
  input  wire logic               suspend_event,
  input  wire logic               bus_reset_event,
  // Endpoint events, one-cycle pulses
  input  wire logic [NUM_EP-1:0]  in_ack_event,
  input  wire logic [NUM_EP-1:0]  out_rx_good_event,
  // Clock restart after suspension
  input  wire logic               resume,
  // Status
  output logic                    module_clock_run,
  output logic                    usb_irq
);
  // One slot per general source and the reserved slot, then an IN and an
  // OUT slot per endpoint.
  localparam int NSRC = `USB_SRC_EP_BASE + 2 * NUM_EP;
  localparam int IW   = $clog2(NSRC);

  // Subaddress map behind the subdata register:
  //   10h  clock stop: any write suspends the module, reads give zero.
  //   28h  source code in bits 6 to 2: writes are dropped.
  //   29h  IN endpoint flags: a one written clears that flag.
  //   2Ah  OUT endpoint flags: a one written clears that flag.
  //   2Bh  general bus flags: a one written clears that flag.
  // Any other subaddress reads zero and drops writes, so software that
  // probes the space sees no side effects.
  //
  // Source codes, highest priority first: 0 setup data, 1 start of frame,
  // 2 setup token, 3 suspend, 4 bus reset, 5 never used, then the IN and
  // OUT sources of endpoints 0 to 3 take codes 6 to 13 in turn.
  //
  // Timing: an event pulse sampled at an edge sets its flag at that edge,
  // and the code and the request output follow one edge later. A read
  // strobe loads read_data at its edge; the value then stands until the
  // next read strobe, so software may sample it whenever it likes.

  // Every register of this module apart from the flag banks lives in this struct; read_data is among
  // them so the subdata port never shows a decode glitch.
  typedef struct packed {
    usb_irq_pkg::byte_t        select;
    usb_irq_pkg::byte_t        read_data;
    usb_irq_pkg::source_code_t code;
    logic                      stopped;
    logic                      pending;
  } main_state_t;

  main_state_t state;
  main_state_t next_state;

  logic [`USB_NUM_GENERAL-1:0] general_set;
  logic [`USB_NUM_GENERAL-1:0] general_flags;
  logic [NUM_EP-1:0]           in_set;
  logic [NUM_EP-1:0]           in_flags;
  logic [NUM_EP-1:0]           out_set;
  logic [NUM_EP-1:0]           out_flags;
  logic [NSRC-1:0]             pending;
  logic                        any_pending;
  logic [IW-1:0]               winner;
  logic                        general_clear;
  logic                        in_clear;
  logic                        out_clear;

  // Returns true when the subdata access goes to the given subaddress.
  function automatic logic selects(
    input usb_irq_pkg::byte_t sel,
    input usb_irq_pkg::byte_t addr
  );
    selects = (sel == addr);
  endfunction : selects

  // Places the source code into its field, reserved bits at zero.
  function automatic usb_irq_pkg::byte_t code_byte(
    input usb_irq_pkg::source_code_t code
  );
    code_byte = 8'h00;
    code_byte[`USB_CODE_MSB:`USB_CODE_LSB] = code; // [R5]
  endfunction : code_byte

  // Widens a flag group into a byte with reserved upper bits at zero.
  function automatic usb_irq_pkg::byte_t flag_byte(
    input logic [7:0] flags
  );
    flag_byte = flags;
  endfunction : flag_byte

  // Position of an endpoint source in the priority order. Each endpoint
  // keeps its IN source just ahead of its OUT source.
  function automatic int ep_slot(
    input int   ep,
    input logic is_out
  );
    ep_slot = `USB_SRC_EP_BASE + 2 * ep + (is_out ? 1 : 0);
  endfunction : ep_slot

  // While the module clock is stopped the bus side sees no events.
  // A real stopped clock would freeze the bus side as well; masking the
  // set inputs models that cheaply and leaves pending flags intact.
  assign general_set = state.stopped ? '0 :
    {bus_reset_event, suspend_event, setup_token_event,
     frame_event, setup_data_event};
  assign in_set  = state.stopped ? '0 : in_ack_event; // [R15]
  assign out_set = state.stopped ? '0 : out_rx_good_event; // [R16]

  // Clears decode the held subaddress, never the one being written.
  assign general_clear =
    data_write && selects(state.select, `USB_SA_GENERAL_FLAGS);
  assign in_clear  = data_write && selects(state.select, `USB_SA_IN_FLAGS);
  assign out_clear = data_write && selects(state.select, `USB_SA_OUT_FLAGS);

  // The three flag banks share one design; each has its own clear strobe
  // and takes the write data as its clear mask.
  usb_flag_bank #(
    .WIDTH       (`USB_NUM_GENERAL)
  ) u_general_flags (
    .clock       (clock),
    .reset       (reset),
    .set         (general_set),
    .clear_write (general_clear),
    .clear_mask  (write_data[`USB_NUM_GENERAL-1:0]),
    .flags       (general_flags)
  );

  usb_flag_bank #(
    .WIDTH       (NUM_EP)
  ) u_in_flags (
    .clock       (clock),
    .reset       (reset),
    .set         (in_set),
    .clear_write (in_clear),
    .clear_mask  (write_data[NUM_EP-1:0]),
    .flags       (in_flags)
  );

  usb_flag_bank #(
    .WIDTH       (NUM_EP)
  ) u_out_flags (
    .clock       (clock),
    .reset       (reset),
    .set         (out_set),
    .clear_write (out_clear),
    .clear_mask  (write_data[NUM_EP-1:0]),
    .flags       (out_flags)
  );

  // Priority order of the sources, lowest index first.
  assign pending[`USB_SRC_SETUP_DATA]  = general_flags[0]; // [R7]
  assign pending[`USB_SRC_FRAME]       = general_flags[1]; // [R7]
  assign pending[`USB_SRC_SETUP_TOKEN] = general_flags[2]; // [R7]
  assign pending[`USB_SRC_SUSPEND]     = general_flags[3]; // [R8]
  assign pending[`USB_SRC_BUS_RESET]   = general_flags[4]; // [R8]
  // The reserved slot has no source, so its code cannot be produced.
  assign pending[`USB_SRC_RESERVED]    = 1'b0; // [R8]

  // Endpoints interleave IN before OUT, endpoint 0 first.
  for (genvar k = 0; k < NUM_EP; k++)
  begin : g_ep
    // [R9] [R10] [R11] [R12] [R14]
    assign pending[ep_slot(k, 1'b0)] = in_flags[k];
    assign pending[ep_slot(k, 1'b1)] = out_flags[k];
  end

  // Only the winner is reported. Software that must see every pending
  // source reads the three flag subregisters instead.
  usb_irq_priority #(
    .N       (NSRC),
    .IW      (IW)
  ) u_priority (
    .pending (pending),
    .any     (any_pending),
    .index   (winner)
  );

  always_comb
  begin
    next_state = state;
    // The request output is registered on the same edge as the code, so
    // the two always agree on the source being reported.
    next_state.pending = any_pending;

    // The code follows the winner while any request is pending and
    // otherwise keeps the last source, so a late read still names it.
    if (any_pending)
    begin
      next_state.code = usb_irq_pkg::source_code_t'(winner); // [R4] [R6]
    end

    // A select write and a data write in one cycle: the data still goes
    // to the old subaddress, which keeps the two-step access order.
    if (select_write)
    begin
      next_state.select = write_data;
    end

    // Any value stops the clock; the data itself is not kept.
    // A stop and a resume in one cycle resolve to stop, so a suspend
    // issued right after a wake-up is never lost.
    if (data_write && selects(state.select, `USB_SA_CLOCK_STOP))
    begin
      next_state.stopped = 1'b1; // [R1]
    end
    else if (resume)
    begin
      next_state.stopped = 1'b0;
    end

    // The select register reads back for debug; a select read wins over a
    // subdata read in the same cycle.
    if (select_read)
    begin
      next_state.read_data = state.select;
    end
    else if (data_read)
    begin
      if (selects(state.select, `USB_SA_CLOCK_STOP))
      begin
        next_state.read_data = `USB_CLOCK_STOP_READ; // [R2]
      end
      else if (selects(state.select, `USB_SA_SOURCE_CODE))
      begin
        // Writes here are ignored; the field is read-only.
        next_state.read_data = code_byte(state.code); // [R3] [R5]
      end
      // Unused upper bits of the flag subregisters read as zero.
      else if (selects(state.select, `USB_SA_IN_FLAGS))
      begin
        next_state.read_data = flag_byte(8'(in_flags));
      end
      else if (selects(state.select, `USB_SA_OUT_FLAGS))
      begin
        next_state.read_data = flag_byte(8'(out_flags));
      end
      else if (selects(state.select, `USB_SA_GENERAL_FLAGS))
      begin
        next_state.read_data = flag_byte(8'(general_flags));
      end
      else
      begin
        // Unmapped subaddresses read zero and keep no state.
        next_state.read_data = `USB_UNMAPPED_READ;
      end
    end
  end

  // Reset is synchronous: a pulse that spans no rising edge is missed,
  // so hold it for at least one edge.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state.select    <= `USB_SELECT_RESET;
      state.read_data <= `USB_READ_DATA_RESET;
      state.code      <= `USB_SOURCE_CODE_RESET; // [R3]
      state.stopped   <= `USB_STOPPED_RESET; // [R2]
      state.pending   <= `USB_PENDING_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Every output comes from a flip-flop, so no event pin reaches a pin of
  // this block within the same cycle.
  assign read_data        = state.read_data;
  assign module_clock_run = ~state.stopped;
  assign usb_irq          = state.pending;
endmodule : usb_irq_identify_and_clock_gate
`default_nettype wire

// ==== src/usb_irq_cfg.svh ====
// Subaddresses, field positions, reset values and source codes.
`ifndef USB_IRQ_CFG_SVH
`define USB_IRQ_CFG_SVH

`define USB_SA_CLOCK_STOP      8'h10
`define USB_SA_SOURCE_CODE     8'h28
`define USB_SA_IN_FLAGS        8'h29
`define USB_SA_OUT_FLAGS       8'h2A
`define USB_SA_GENERAL_FLAGS   8'h2B

`define USB_SELECT_RESET       8'h00
`define USB_CLOCK_STOP_READ    8'h00
`define USB_SOURCE_CODE_RESET  5'h00
`define USB_UNMAPPED_READ      8'h00
`define USB_READ_DATA_RESET    8'h00
`define USB_STOPPED_RESET      1'b0
`define USB_PENDING_RESET      1'b0

`define USB_CODE_MSB           6
`define USB_CODE_LSB           2

`define USB_NUM_ENDPOINTS      4
`define USB_NUM_GENERAL        5
`define USB_NUM_SOURCES        14

`define USB_SRC_SETUP_DATA     0
`define USB_SRC_FRAME          1
`define USB_SRC_SETUP_TOKEN    2
`define USB_SRC_SUSPEND        3
`define USB_SRC_BUS_RESET      4
`define USB_SRC_RESERVED       5
`define USB_SRC_EP_BASE        6

`endif

// ==== src/usb_irq_pkg.sv ====
// Shared types of the USB interrupt identification block.
`default_nettype none
package usb_irq_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [4:0] source_code_t;
endpackage : usb_irq_pkg
`default_nettype wire

// ==== src/usb_flag_bank.sv ====
// Sticky request flags cleared by writing one to a bit.
`default_nettype none
module usb_flag_bank #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Hardware events, one-cycle pulses
  input  wire logic [WIDTH-1:0] set,
  // Software clear
  input  wire logic             clear_write,
  input  wire logic [WIDTH-1:0] clear_mask,
  // Flag state
  output logic      [WIDTH-1:0] flags
);
  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } bank_state_t;

  bank_state_t state;
  bank_state_t next_state;

  always_comb
  begin
    next_state = state;
    // An event in the clear cycle survives the clear.
    if (clear_write)
    begin
      next_state.flags = state.flags & ~clear_mask; // [R17]
    end
    next_state.flags = next_state.flags | set;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign flags = state.flags;
endmodule : usb_flag_bank
`default_nettype wire

// ==== src/usb_irq_priority.sv ====
// Fixed priority encoder: the lowest pending index wins.
`default_nettype none
module usb_irq_priority #(
  parameter int N  = 14,
  parameter int IW = $clog2(N)
) (
  // Pending requests
  input  wire logic [N-1:0]  pending,
  // Winner
  output logic               any,
  output logic      [IW-1:0] index
);
  always_comb
  begin
    any   = 1'b0;
    index = '0;
    // Scan downward so the lowest set index is the last to be taken.
    for (int i = N - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        any   = 1'b1;
        index = IW'(i); // [R6]
      end
    end
  end
endmodule : usb_irq_priority
`default_nettype wire

// ==== testbench/usb_irq_identify_and_clock_gate_chk.sv ====
// Assertions on the ports of the USB interrupt identification block.
`default_nettype none
module usb_irq_identify_and_clock_gate_chk #(
  parameter int NUM_EP = 4
) (
  // Clock and reset
  input wire logic               clock,
  input wire logic               reset,
  // Register port
  input wire logic               select_write,
  input wire logic               select_read,
  input wire logic               data_write,
  input wire logic               data_read,
  input wire usb_irq_pkg::byte_t write_data,
  input wire usb_irq_pkg::byte_t read_data,
  // Bus events
  input wire logic               setup_data_event,
  input wire logic               frame_event,
  input wire logic               setup_token_event,
  input wire logic               suspend_event,
  input wire logic               bus_reset_event,
  input wire logic [NUM_EP-1:0]  in_ack_event,
  input wire logic [NUM_EP-1:0]  out_rx_good_event,
  // Clock restart and status
  input wire logic               resume,
  input wire logic               module_clock_run,
  input wire logic               usb_irq
);
  usb_irq_pkg::byte_t sel;
  logic               ev;
  assign ev = setup_data_event | frame_event | setup_token_event |
              suspend_event | bus_reset_event | (|in_ack_event) |
              (|out_rx_good_event);
  // The select register is mirrored because the checker sees only ports.
  always_ff @(posedge clock)
  begin
    if (reset)
      sel <= 8'h00;
    else if (select_write)
      sel <= write_data;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_rd(a); data_read && !select_read && sel == a; endsequence
  sequence s_stop; data_write && sel == 8'h10; endsequence
  property p_stop; s_stop |=> !module_clock_run; endproperty
  a_stop: assert property (p_stop) else $error("clock kept running");
  property p_stay; !module_clock_run && !resume |=> !module_clock_run;
  endproperty
  a_stay: assert property (p_stay) else $error("clock restarted");
  property p_rd_stop; s_rd(8'h10) |=> read_data == 8'h00; endproperty
  a_rd_stop: assert property (p_rd_stop) else $error("stop reg read");
  property p_rsv;
    s_rd(8'h28) |=> read_data[7] == 1'b0 && read_data[1:0] == 2'b00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_no5; s_rd(8'h28) |=> read_data[6:2] != 5'h05; endproperty
  a_no5: assert property (p_no5) else $error("code five seen");
  property p_raise; ev && module_clock_run |-> ##2 usb_irq; endproperty
  a_raise: assert property (p_raise) else $error("no request");
  property p_hold; !data_read && !select_read |=> $stable(read_data);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rst;
    disable iff (1'b0)
    reset |=> module_clock_run && !usb_irq && read_data == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
endmodule : usb_irq_identify_and_clock_gate_chk
bind usb_irq_identify_and_clock_gate usb_irq_identify_and_clock_gate_chk #(
  .NUM_EP(NUM_EP)
) i_chk (
  .clock, .reset, .select_write, .select_read, .data_write, .data_read,
  .write_data, .read_data, .setup_data_event, .frame_event,
  .setup_token_event, .suspend_event, .bus_reset_event, .in_ack_event,
  .out_rx_good_event, .resume, .module_clock_run, .usb_irq
);
`default_nettype wire

// ==== testbench/usb_irq_identify_and_clock_gate_tb.sv ====
// Self-checking bench for the USB interrupt identification block.
`default_nettype none
module usb_irq_identify_and_clock_gate_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clock = 1'b0;
  logic               reset = 1'b1;
  logic               select_write = 1'b0;
  logic               select_read = 1'b0;
  logic               data_write = 1'b0;
  logic               data_read = 1'b0;
  logic               resume = 1'b0;
  usb_irq_pkg::byte_t write_data = 8'h00;
  usb_irq_pkg::byte_t read_data;
  logic [13:0]        src = 14'h0000;
  logic               module_clock_run;
  logic               usb_irq;
  int                 n_fail = 0;
  int                 n_checks = 0;
  always #2.5 clock = ~clock;
  // Bit i of src is the event whose source code is i.
  usb_irq_identify_and_clock_gate #(.NUM_EP(4)) i_dut (
    .clock, .reset, .select_write, .select_read, .data_write, .data_read,
    .write_data, .read_data,
    .setup_data_event(src[0]), .frame_event(src[1]),
    .setup_token_event(src[2]), .suspend_event(src[3]),
    .bus_reset_event(src[4]),
    .in_ack_event({src[12], src[10], src[8], src[6]}),
    .out_rx_good_event({src[13], src[11], src[9], src[7]}),
    .resume, .module_clock_run, .usb_irq
  );
  task automatic finish_test;
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic chk(input usb_irq_pkg::byte_t got, exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One-cycle strobe; lowered on the edge that takes it.
  task automatic op(input logic [3:0] k, input usb_irq_pkg::byte_t d);
    @(posedge clock);
    {select_write, select_read, data_write, data_read} <= k;
    write_data <= d;
    @(posedge clock);
    {select_write, select_read, data_write, data_read} <= 4'h0;
    #1;
  endtask : op
  task automatic wr(input usb_irq_pkg::byte_t a, d);
    op(4'h8, a);
    op(4'h2, d);
  endtask : wr
  task automatic rd(input usb_irq_pkg::byte_t a, exp);
    op(4'h8, a);
    op(4'h1, 8'h00);
    chk(read_data, exp);
  endtask : rd
  task automatic pulse(input logic [13:0] v);
    @(posedge clock);
    src <= v;
    @(posedge clock);
    src <= 14'h0000;
  endtask : pulse
  task automatic wait_irq(input logic v);
    int i;
    for (i = 0; i < 8 && usb_irq !== v; i++)
    begin
      @(posedge clock);
      #1;
    end
    chk({7'h00, usb_irq}, {7'h00, v});
    if (usb_irq !== v)
      finish_test();
  endtask : wait_irq
  function automatic usb_irq_pkg::byte_t code(input int i);
    return {1'b0, i[4:0], 2'b00};
  endfunction : code
  task automatic clr(input int i);
    if (i < 5)
      wr(8'h2B, 8'h01 << i);
    else
      wr(i[0] ? 8'h2A : 8'h29, 8'h01 << ((i - 6) / 2));
  endtask : clr
  task automatic t_reset;
    rd(8'h28, 8'h00);
    rd(8'h10, 8'h00);
    op(4'h4, 8'h00);
    chk(read_data, 8'h10);
    chk({7'h00, module_clock_run}, 8'h01);
  endtask : t_reset
  task automatic t_priority;
    int i;
    pulse(14'h3FDF);
    wait_irq(1'b1);
    wr(8'h2B, 8'h00);
    rd(8'h28, 8'h00);
    for (i = 0; i < 14; i++)
      if (i != 5)
      begin
        rd(8'h28, code(i));
        clr(i);
      end
    wait_irq(1'b0);
    rd(8'h28, code(13));
  endtask : t_priority
  task automatic t_update;
    pulse(14'h1000);
    rd(8'h28, code(12));
    pulse(14'h0001);
    rd(8'h28, code(0));
    wr(8'h28, 8'h7C);
    clr(0);
    rd(8'h28, code(12));
    clr(12);
  endtask : t_update
  // A stopped module must not latch events, so the request stays low.
  task automatic t_stop(input usb_irq_pkg::byte_t v);
    wr(8'h10, v);
    chk({7'h00, module_clock_run}, 8'h00);
    pulse(14'h0002);
    repeat (3) @(posedge clock);
    #1;
    chk({7'h00, usb_irq}, 8'h00);
    rd(8'h10, 8'h00);
    @(posedge clock);
    resume <= 1'b1;
    @(posedge clock);
    resume <= 1'b0;
    #1;
    chk({7'h00, module_clock_run}, 8'h01);
  endtask : t_stop
  // A reset in mid-run must bring back the zero code although the code
  // otherwise keeps its last source.
  task automatic t_rearm;
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(8'h28, 8'h00);
    chk({7'h00, module_clock_run}, 8'h01);
  endtask : t_rearm
  initial
  begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_priority();
    t_rearm();
    t_update();
    t_stop(8'h00);
    t_stop(8'h5A);
    t_stop(8'hFF);
    rd(8'h3F, 8'h00);
    finish_test();
  end
endmodule : usb_irq_identify_and_clock_gate_tb
`default_nettype wire
